// ==== pkg/host_port_params.svh ====
// Constants shared by both ends of the split-strobe host port
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define ADDR_BITS          17
`define DATA_BITS          16
`define WINDOW_BYTES       32'h0002_0000
`define BUFFER_BYTES       32'h0001_4000
`define REG_BYTES          32'h0000_0020
`define REG_BASE           17'h1_FFE0
`define REGION_BYTES       32'h0020_0000
`define BUS_MODE_SPLIT     3'h7
`define ENDIAN_LITTLE      1'h0
`define ENDIAN_BIG         1'h1
`define LINK_PERIOD_NS     200
`define CLOCK_PERIOD_NS    25
`define LINK_DIV_HALF      ((`LINK_PERIOD_NS / `CLOCK_PERIOD_NS) / 2)
`define REFRESH_PERIOD     16
`define REFRESH_BUSY       3
`define ACCESS_CYCLES      2

`define OFS_CTRL           32'h0000_0000
`define OFS_ADDR           32'h0000_0004
`define OFS_WDATA          32'h0000_0008
`define OFS_RDATA          32'h0000_000C
`define OFS_STATUS         32'h0000_0010
`define CTRL_GO_BIT        0
`define CTRL_WRITE_BIT     1
`define CTRL_LANE_LO_BIT   2
`define CTRL_LANE_HI_BIT   3
`define STAT_BUSY_BIT      0
`define STAT_DONE_BIT      1
`define STAT_ENDIAN_BIT    2

`endif

// ==== pkg/host_port_pkg.sv ====
// Types shared by both ends of the split-strobe host port
package host_port_pkg;
	// Device access engine states, Gray coded along the usual path
	typedef enum logic [1:0] {
		DEV_IDLE   = 2'b00,
		DEV_ARB    = 2'b01,
		DEV_ACCESS = 2'b11,
		DEV_HOLD   = 2'b10
	} dev_state_type;

	// Host strobe engine states, Gray coded except the HST_END to HST_IDLE return
	typedef enum logic [2:0] {
		HST_IDLE   = 3'b000,
		HST_SETUP  = 3'b001,
		HST_STROBE = 3'b011,
		HST_WAIT   = 3'b010,
		HST_END    = 3'b110
	} host_state_type;
endpackage

// ==== pkg/host_port_if.sv ====
// Pin bundle between the host glue and the display device port
`timescale 1ns/10ps
interface host_port_if;
	logic        hostInterfaceClock;       // Link clock from host
	logic [16:0] deviceAddressIn;          // Byte address
	logic [15:0] hostDataOut;              // Host data drive
	logic        hostDataOe;               // Host drives data lines
	logic [15:0] devDataOut;               // Device data drive
	logic        devDataOe;                // Device drives data lines
	logic [15:0] deviceDataLines;          // Resolved data wire
	logic        selectN;                  // Device select, low active
	logic        lowByteWriteStrobeN;      // Low lane write
	logic        highByteWriteStrobeN;     // High lane write
	logic        lowByteReadStrobeN;       // Low lane read
	logic        highByteReadStrobeN;      // High lane read
	logic        holdOffN;                 // Device stall, low active
	logic        busStatusStrapN;          // Tied low by host
	logic        endianStrap;              // Byte order strap
	logic [2:0]  busModeStrap;             // Hi, mid, lo mode straps
	logic        resetN;                   // Device reset, low active

	// Wire resolution: device drive wins over host drive, else pulled high
	assign deviceDataLines = devDataOe ? devDataOut :
		(hostDataOe ? hostDataOut : 16'hFFFF);

	modport device (
		input  hostInterfaceClock, deviceAddressIn, deviceDataLines, selectN,
		input  lowByteWriteStrobeN, highByteWriteStrobeN,
		input  lowByteReadStrobeN, highByteReadStrobeN,
		input  busStatusStrapN, endianStrap, busModeStrap, resetN,
		output devDataOut, devDataOe, holdOffN
	);
	modport host (
		output hostInterfaceClock, deviceAddressIn, hostDataOut, hostDataOe, selectN,
		output lowByteWriteStrobeN, highByteWriteStrobeN,
		output lowByteReadStrobeN, highByteReadStrobeN,
		output busStatusStrapN, endianStrap, busModeStrap, resetN,
		input  deviceDataLines, holdOffN
	);
endinterface

// ==== logic/split_strobe_device.sv ====
// Display device end of the split-strobe 16-bit host port
// Contract
// - Sixteen-bit port, select plus per-lane strobes
// - Port runs on its own host clock
// - Host wires address and data straight through
// - Big-endian 32-bit host uses high lanes
// - Host decodes high address for select
// - Low write strobes write respective byte lanes
// - Low read strobes read respective byte lanes
// - Hold-off asserted until data valid/accepted
// - Refresh collision stalls host until granted
// - Active-high wait hosts invert hold-off
// - Glue drives acknowledge only while selected
// - Straps sampled at reset rising edge
// - Endian strap: 0 little, 1 big
// - Mode straps 111 with status 0: split
// - Status pin ignored in cycles, tied low
// - 128K window, 80K buffer, top 32 registers
// - Window aliases through 2M select region
// - Host: no wait states, no auto-ack
// - Host declares port sixteen bits wide
// - Host disables burst reads and writes
// - Host byte enables on writes only; glue also gates read strobes by lane
// - Host select space and valid settings
`timescale 1ns/10ps
`include "host_port_params.svh"
module split_strobe_device #(
	parameter int BUF_WORDS = 40960,   // 80K bytes as 16-bit words
	parameter int REG_WORDS = 16       // 32 bytes of registers
) (
	input  wire logic                 clock,
	input  wire logic                 srst,
	host_port_if.device               port,
	output logic                      splitMode,
	output logic                      bigEndian,
	output logic                      refreshActive
);
	import host_port_pkg::*;

	// Sizes are refused at elaboration; the decode below assumes the documented map
	if (BUF_WORDS * 2 != `BUFFER_BYTES || REG_WORDS * 2 != `REG_BYTES) begin : gBadSize
		$error("split_strobe_device: memory sizes do not fit the window");
	end

	// Storage: display buffer and register file
	logic [15:0] bufMem [BUF_WORDS];   // Display buffer words
	logic [15:0] regMem [REG_WORDS];   // Register words

	// State of the device end, apart from the bufMem and regMem storage
	typedef struct packed {
		logic [1:0]    clkSync;       // Link clock synchroniser
		logic          clkPrev;       // Last synced link clock
		logic [1:0]    rstSync;       // Reset pin synchroniser
		logic          rstPrev;
		logic [1:0]    selSync;
		logic [1:0]    wrLoSync;
		logic [1:0]    wrHiSync;
		logic [1:0]    rdLoSync;
		logic [1:0]    rdHiSync;
		dev_state_type state;
		logic          isWrite;
		logic          laneLo;
		logic          laneHi;
		logic [16:0]   addr;
		logic [15:0]   wdata;
		logic [15:0]   rdata;
		logic          dataOe;
		logic          holdN;
		logic [3:0]    refreshCnt;    // Refresh slot timer
		logic [1:0]    busyCnt;       // Refresh occupancy
		logic [1:0]    accCnt;        // Access length counter
		logic          refreshOn;     // Registered copy for the status output
		logic          split;
		logic          big;
	} dev_type;

	dev_type cur_r;
	dev_type cur_nxt;

	logic        linkRise;           // Host clock rising edge seen
	logic        selActive;          // Synced select
	logic        anyWr;
	logic        anyRd;
	logic        hitReg;             // Address lands in register block
	logic        hitBuf;             // Address lands in display buffer
	logic [15:0] memWord;            // Word addressed now
	logic [16:0] evenAddr;

	assign linkRise  = cur_r.clkSync[1] & ~cur_r.clkPrev;
	assign selActive = ~cur_r.selSync[1];
	assign anyWr     = ~cur_r.wrLoSync[1] | ~cur_r.wrHiSync[1];
	assign anyRd     = ~cur_r.rdLoSync[1] | ~cur_r.rdHiSync[1];
	assign evenAddr  = {cur_r.addr[16:1], 1'b0};
	assign hitReg    = evenAddr >= `REG_BASE;
	assign hitBuf    = {15'h0000, evenAddr} < `BUFFER_BYTES;
	assign memWord   = hitReg ? regMem[evenAddr[4:1]] :
		(hitBuf ? bufMem[evenAddr[16:1]] : 16'h0000);

	// Next-state logic
	always_comb begin
		cur_nxt = cur_r;
		// Clock, reset, select and strobe pins pass two flops; address, data and straps are read directly
		cur_nxt.clkSync  = {cur_r.clkSync[0], port.hostInterfaceClock};
		cur_nxt.clkPrev  = cur_r.clkSync[1];
		cur_nxt.rstSync  = {cur_r.rstSync[0], port.resetN};
		cur_nxt.rstPrev  = cur_r.rstSync[1];
		cur_nxt.selSync  = {cur_r.selSync[0], port.selectN};
		cur_nxt.wrLoSync = {cur_r.wrLoSync[0], port.lowByteWriteStrobeN};
		cur_nxt.wrHiSync = {cur_r.wrHiSync[0], port.highByteWriteStrobeN};
		cur_nxt.rdLoSync = {cur_r.rdLoSync[0], port.lowByteReadStrobeN};
		cur_nxt.rdHiSync = {cur_r.rdHiSync[0], port.highByteReadStrobeN};

		// Straps caught on the rising edge of the device reset pin
		if (cur_r.rstSync[1] & ~cur_r.rstPrev) begin
			cur_nxt.split = (port.busModeStrap == `BUS_MODE_SPLIT)
				& ~port.busStatusStrapN;
			cur_nxt.big   = port.endianStrap == `ENDIAN_BIG;
		end

		// Refresh slot steals the memory periodically, on host clock ticks
		if (linkRise) begin
			cur_nxt.refreshCnt = cur_r.refreshCnt + 4'h1;
			if (cur_r.refreshCnt == 4'(`REFRESH_PERIOD - 1))
				cur_nxt.busyCnt = 2'(`REFRESH_BUSY);
			else if (cur_r.busyCnt != 2'h0)
				cur_nxt.busyCnt = cur_r.busyCnt - 2'h1;
		end
		// Output flag taken from the next count so it tracks busyCnt exactly
		cur_nxt.refreshOn = cur_nxt.busyCnt != 2'h0;

		// Access engine; the status pin is never looked at here
		unique case (cur_r.state)
			DEV_IDLE: begin
				cur_nxt.holdN  = 1'b1;
				cur_nxt.dataOe = 1'b0;
				if (cur_r.split && selActive && (anyWr || anyRd) && cur_r.rstSync[1]) begin
					cur_nxt.holdN   = 1'b0;
					cur_nxt.isWrite = anyWr;
					cur_nxt.laneLo  = anyWr ? ~cur_r.wrLoSync[1] : ~cur_r.rdLoSync[1];
					cur_nxt.laneHi  = anyWr ? ~cur_r.wrHiSync[1] : ~cur_r.rdHiSync[1];
					cur_nxt.addr    = port.deviceAddressIn;
					cur_nxt.wdata   = port.deviceDataLines;
					cur_nxt.state   = DEV_ARB;
				end
			end
			DEV_ARB: begin
				// Stay stalled while refresh owns the memory
				if (cur_r.busyCnt == 2'h0) begin
					cur_nxt.accCnt = 2'(`ACCESS_CYCLES);
					cur_nxt.state  = DEV_ACCESS;
				end
			end
			DEV_ACCESS: begin
				if (cur_r.accCnt != 2'h0) begin
					cur_nxt.accCnt = cur_r.accCnt - 2'h1;
				end else begin
					cur_nxt.rdata  = memWord;
					cur_nxt.dataOe = ~cur_r.isWrite;
					cur_nxt.holdN  = 1'b1;
					cur_nxt.state  = DEV_HOLD;
				end
			end
			DEV_HOLD: begin
				// Wait for the host to drop its strobes or select
				if (!selActive || !(anyWr || anyRd)) begin
					cur_nxt.dataOe = 1'b0;
					cur_nxt.state  = DEV_IDLE;
				end
			end
		endcase

		if (srst) begin
			cur_nxt            = '0;
			cur_nxt.clkSync    = cur_r.clkSync;
			cur_nxt.state      = DEV_IDLE;
			cur_nxt.holdN      = 1'b1;
		end
	end

	// Memory write on the last access cycle
	always_ff @(posedge clock) begin
		if (!srst && cur_r.state == DEV_ACCESS && cur_r.accCnt == 2'h0 && cur_r.isWrite) begin
			if (hitReg) begin
				if (cur_r.laneLo) regMem[evenAddr[4:1]][7:0]  <= cur_r.wdata[7:0];
				if (cur_r.laneHi) regMem[evenAddr[4:1]][15:8] <= cur_r.wdata[15:8];
			end else if (hitBuf) begin
				if (cur_r.laneLo) bufMem[evenAddr[16:1]][7:0]  <= cur_r.wdata[7:0];
				if (cur_r.laneHi) bufMem[evenAddr[16:1]][15:8] <= cur_r.wdata[15:8];
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		cur_r <= cur_nxt;
	end

	assign port.devDataOut = cur_r.rdata;
	assign port.devDataOe  = cur_r.dataOe;
	assign port.holdOffN   = cur_r.holdN;
	assign splitMode       = cur_r.split;
	assign bigEndian       = cur_r.big;
	assign refreshActive   = cur_r.refreshOn;
endmodule

// ==== logic/split_strobe_host.sv ====
// Host glue end: APB-programmed strobe generator for the device port
`timescale 1ns/10ps
`include "host_port_params.svh"
module split_strobe_host #(
	parameter logic STRAP_BIG = 1'b1   // Endian strap value driven
) (
	input  wire logic                 clock,
	input  wire logic                 srst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	host_port_if.host                 port
);
	import host_port_pkg::*;

	// Complete state of the host end
	typedef struct packed {
		host_state_type state;
		logic [1:0]     waitSync;      // Hold-off synchroniser
		logic [2:0]     divCnt;        // Link clock divider
		logic           linkClk;
		logic [3:0]     rstCnt;        // Device reset stretch
		logic           devRstN;
		logic           isWrite;
		logic           laneLo;
		logic           laneHi;
		logic [20:0]    addr;          // Address within 2M region
		logic [15:0]    wdata;
		logic [15:0]    rdata;
		logic           done;
		logic           selN;
		logic           strobe;
		logic           holdSeen;      // Hold-off seen low in this cycle
		logic           dataOe;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
	} host_type;

	host_type cur_r;
	host_type cur_nxt;
	logic     access;
	logic     busy;

	assign access = psel & penable & ~cur_r.pready;
	assign busy   = cur_r.state != HST_IDLE;

	// Next-state logic
	always_comb begin
		cur_nxt        = cur_r;
		cur_nxt.pready = 1'b0;
		cur_nxt.waitSync = {cur_r.waitSync[0], port.holdOffN};

		// Link clock made here by division
		if (cur_r.divCnt == 3'(`LINK_DIV_HALF - 1)) begin
			cur_nxt.divCnt  = 3'h0;
			cur_nxt.linkClk = ~cur_r.linkClk;
		end else begin
			cur_nxt.divCnt = cur_r.divCnt + 3'h1;
		end
		// Device reset held low a while, then released so straps are caught
		if (cur_r.rstCnt != 4'hF)
			cur_nxt.rstCnt = cur_r.rstCnt + 4'h1;
		else
			cur_nxt.devRstN = 1'b1;

		// APB slave, one wait state: answer prepared on the first access edge
		if (access) begin
			cur_nxt.pready  = 1'b1;
			cur_nxt.pslverr = 1'b0;
			cur_nxt.prdata  = 32'h0000_0000;
			unique case (paddr)
				`OFS_CTRL:   cur_nxt.prdata = 32'h0000_0000;
				`OFS_ADDR:   cur_nxt.prdata = {11'h000, cur_r.addr};
				`OFS_WDATA:  cur_nxt.prdata = {16'h0000, cur_r.wdata};
				`OFS_RDATA:  cur_nxt.prdata = {16'h0000, cur_r.rdata};
				`OFS_STATUS: cur_nxt.prdata = {29'h0, STRAP_BIG, cur_r.done, busy};
				default:     cur_nxt.pslverr = 1'b1;
			endcase
		end
		// Writes land only on the edge where pready is seen high
		if (psel && penable && cur_r.pready && pwrite) begin
			unique case (paddr)
				`OFS_CTRL: begin
					if (pwdata[`CTRL_GO_BIT] && !busy) begin
						cur_nxt.isWrite = pwdata[`CTRL_WRITE_BIT];
						cur_nxt.laneLo  = pwdata[`CTRL_LANE_LO_BIT];
						cur_nxt.laneHi  = pwdata[`CTRL_LANE_HI_BIT];
						cur_nxt.done    = 1'b0;
						cur_nxt.state   = HST_SETUP;
					end
				end
				`OFS_ADDR:  cur_nxt.addr  = pwdata[20:0];
				`OFS_WDATA: cur_nxt.wdata = pwdata[15:0];
				default:    ;
			endcase
		end

		// Strobe engine: single transfers, acknowledged only by hold-off
		unique case (cur_r.state)
			HST_IDLE: begin
				cur_nxt.selN   = 1'b1;
				cur_nxt.strobe = 1'b0;
				cur_nxt.dataOe = 1'b0;
			end
			HST_SETUP: begin
				cur_nxt.selN     = 1'b0;
				cur_nxt.holdSeen = 1'b0;
				cur_nxt.dataOe   = cur_r.isWrite;
				cur_nxt.state  = HST_STROBE;
			end
			HST_STROBE: begin
				cur_nxt.strobe = 1'b1;
				cur_nxt.state  = HST_WAIT;
			end
			HST_WAIT: begin
				// Device sees the strobe late, so only a rise after a seen low acknowledges
				if (!cur_r.waitSync[1])
					cur_nxt.holdSeen = 1'b1;
				// High hold-off is the acknowledge, and only while selected
				if (cur_r.holdSeen && cur_r.waitSync[1] && !cur_r.selN) begin
					cur_nxt.rdata  = port.deviceDataLines;
					cur_nxt.state  = HST_END;
				end
			end
			HST_END: begin
				cur_nxt.strobe = 1'b0;
				cur_nxt.selN   = 1'b1;
				cur_nxt.dataOe = 1'b0;
				if (!cur_r.strobe && cur_r.waitSync[1]) begin
					cur_nxt.done  = 1'b1;
					cur_nxt.state = HST_IDLE;
				end
			end
			default: cur_nxt.state = HST_IDLE;
		endcase

		if (srst) begin
			cur_nxt       = '0;
			cur_nxt.state = HST_IDLE;
			cur_nxt.selN  = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		cur_r <= cur_nxt;
	end

	// Pins, straight from state; strobes gated by direction and lane
	assign port.hostInterfaceClock   = cur_r.linkClk;
	assign port.deviceAddressIn      = cur_r.addr[16:0];
	assign port.hostDataOut          = cur_r.wdata;
	assign port.hostDataOe           = cur_r.dataOe;
	assign port.selectN              = cur_r.selN;
	assign port.lowByteWriteStrobeN  = ~(cur_r.strobe & cur_r.isWrite & cur_r.laneLo);
	assign port.highByteWriteStrobeN = ~(cur_r.strobe & cur_r.isWrite & cur_r.laneHi);
	assign port.lowByteReadStrobeN   = ~(cur_r.strobe & ~cur_r.isWrite & cur_r.laneLo);
	assign port.highByteReadStrobeN  = ~(cur_r.strobe & ~cur_r.isWrite & cur_r.laneHi);
	assign port.busStatusStrapN      = 1'b0;
	assign port.endianStrap          = STRAP_BIG;
	assign port.busModeStrap         = `BUS_MODE_SPLIT;
	assign port.resetN               = cur_r.devRstN;
	assign prdata                    = cur_r.prdata;
	assign pready                    = cur_r.pready;
	assign pslverr                   = cur_r.pslverr;
endmodule

// ==== tb/host_port_props.sv ====
// Pin-level checks between host glue and device
`timescale 1ns/10ps
module host_port_props (
	input wire logic       clock,
	input wire logic       srst,
	input wire logic       hostInterfaceClock,
	input wire logic       selectN,
	input wire logic       lowByteWriteStrobeN,
	input wire logic       highByteWriteStrobeN,
	input wire logic       lowByteReadStrobeN,
	input wire logic       highByteReadStrobeN,
	input wire logic       holdOffN,
	input wire logic       devDataOe,
	input wire logic       hostDataOe,
	input wire logic       busStatusStrapN,
	input wire logic [2:0] busModeStrap
);
	// Lane strobe summaries
	wire anyRd = !(lowByteReadStrobeN & highByteReadStrobeN);
	wire anyWr = !(lowByteWriteStrobeN & highByteWriteStrobeN);
	wire idle  = !anyRd & !anyWr;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Divider by 8 gives 4 high cycles
	link_half_a: assert property ($rose(hostInterfaceClock) |->
		hostInterfaceClock [*4] ##1 !hostInterfaceClock) else $error("link clock half period");
	no_fight_a: assert property (!(devDataOe && hostDataOe)) else $error("data contention");
	strobe_sel_a: assert property (!idle |-> !selectN) else $error("strobe outside select");
	sel_first_a: assert property ($fell(idle) |-> !$past(selectN)) else $error("select late");
	dir_excl_a: assert property (!(anyRd && anyWr)) else $error("read and write together");
	wr_drive_a: assert property (anyWr |-> hostDataOe) else $error("write data missing");
	rd_drive_a: assert property ($rose(devDataOe) |-> anyRd && !selectN) else $error("stray drive");
	hold_cause_a: assert property ($fell(holdOffN) |-> !idle) else $error("hold-off unprovoked");
	// Host must see hold-off high on two samples first
	release_late_a: assert property ($rose(idle) |->
		$past(holdOffN, 1) && $past(holdOffN, 2)) else $error("strobe released early");
	rd_valid_a: assert property ($rose(holdOffN) && anyRd |-> ##[0:1] devDataOe)
		else $error("read data absent");
	stall_bound_a: assert property ($fell(idle) |-> ##[1:400] $rose(idle))
		else $error("cycle never ended");
	strap_tie_a: assert property (!busStatusStrapN && busModeStrap == 3'h7)
		else $error("mode straps wrong");
	// Main scenarios
	wr_c: cover property ($fell(idle) && anyWr);
	rd_c: cover property ($fell(idle) && anyRd);
	stall_c: cover property (!holdOffN [*8]);
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench: APB to host glue, device across the pins
`timescale 1ns/10ps
`include "host_port_params.svh"
module testbench;
	import host_port_pkg::*;
	logic        clock, srst;               // Clock, reset
	logic        psel, penable, pwrite;     // APB control
	logic [31:0] paddr, pwdata, prdata;     // APB data
	logic        pready, pslverr;           // APB answer
	logic        splitMode, bigEndian, refr; // Device status
	logic [31:0] seed = 32'h5635FB67;       // Random state
	logic [15:0] memModel [int];            // Word model
	logic [15:0] known [int];               // Written bits
	int          miscompares, totalChecks;  // Counters
	logic [31:0] v;                          // Scratch
	logic        e;                          // Scratch
	host_port_if hp();
	split_strobe_device split_strobe_device_inst (.clock(clock), .srst(srst), .port(hp),
		.splitMode(splitMode), .bigEndian(bigEndian), .refreshActive(refr));
	split_strobe_host split_strobe_host_inst (.clock(clock), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port(hp));
	host_port_props host_port_props_inst (.clock(clock), .srst(srst),
		.hostInterfaceClock(hp.hostInterfaceClock), .selectN(hp.selectN),
		.lowByteWriteStrobeN(hp.lowByteWriteStrobeN), .highByteWriteStrobeN(hp.highByteWriteStrobeN),
		.lowByteReadStrobeN(hp.lowByteReadStrobeN), .highByteReadStrobeN(hp.highByteReadStrobeN),
		.holdOffN(hp.holdOffN), .devDataOe(hp.devDataOe), .hostDataOe(hp.hostDataOe),
		.busStatusStrapN(hp.busStatusStrapN), .busModeStrap(hp.busModeStrap));
	// 40 MHz clock
	initial clock = 1'b0;
	always #12.5 clock = ~clock;
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Verdict and end of run
	task automatic final_report();
		$display("Checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One APB transfer; held until pready seen at an edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One device access through the glue registers, checked against the model
	task automatic op(input logic w, input logic [1:0] ln, input logic [31:0] a);
		logic [15:0] d, lm, ex, mk;
		int n, wi;
		d = 16'(rnd());
		wi = (a & 32'h1FFFF) >> 1;
		lm = {{8{ln[1]}}, {8{ln[0]}}};
		apb(1'b1, `OFS_ADDR, a, v, e);
		apb(1'b1, `OFS_WDATA, {16'h0000, d}, v, e);
		apb(1'b1, `OFS_CTRL, {28'h0, ln, w, 1'b1}, v, e);
		n = 0;
		do begin
			apb(1'b0, `OFS_STATUS, 32'h0, v, e);
			n++;
		end while (v[1:0] !== 2'b10 && n < 60);
		check("done flag", 32'h2, {30'h0, v[1:0]});
		if (v[1:0] !== 2'b10) final_report();
		apb(1'b0, `OFS_RDATA, 32'h0, v, e);
		// Gap between buffer and registers: reads 0, writes dropped
		if (wi * 2 >= 32'h14000 && wi * 2 < 32'h1FFE0) begin
			if (!w) check("gap read", 32'h0, {16'h0, v[15:0] & lm});
		end else if (w) begin
			if (!known.exists(wi)) known[wi] = 16'h0;
			if (!memModel.exists(wi)) memModel[wi] = 16'h0;
			memModel[wi] = (memModel[wi] & ~lm) | (d & lm);
			known[wi] |= lm;
		end else if (known.exists(wi)) begin
			mk = lm & known[wi];
			ex = memModel[wi] & mk;
			check("read data", {16'h0, ex}, {16'h0, v[15:0] & mk});
		end
	endtask
	// Watchdog
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		final_report();
	end
	// Main sequence
	initial begin
		logic [31:0] edges [5];
		logic [31:0] a;
		int          cnt;
		edges = '{32'h0, 32'h13FFE, 32'h14000, 32'h1FFE0, 32'h1FFFE};
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		srst = 1'b1;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		repeat (60) @(posedge clock);
		check("split mode", 32'h1, {31'h0, splitMode});
		check("big endian", 32'h1, {31'h0, bigEndian});
		// Refresh share over two whole refresh periods of the link clock
		cnt = 0;
		repeat (2 * `REFRESH_PERIOD * (`LINK_PERIOD_NS / `CLOCK_PERIOD_NS)) begin
			@(posedge clock);
			if (refr === 1'b1) cnt++;
		end
		check("refresh share", 32'(2 * `REFRESH_BUSY * (`LINK_PERIOD_NS / `CLOCK_PERIOD_NS)),
			32'(cnt));
		apb(1'b0, `OFS_STATUS, 32'h0, v, e);
		check("status endian", 32'h1, {31'h0, v[`STAT_ENDIAN_BIT]});
		apb(1'b0, 32'h0000_0020, 32'h0, v, e);
		check("unmapped error", 32'h1, {31'h0, e});
		// Boundaries: write both lanes, then low lane alone; read high lane alone, then both lanes
		foreach (edges[i]) begin
			op(1'b1, 2'b11, edges[i]);
			op(1'b1, 2'b01, edges[i] | 32'h0002_0000);
			op(1'b0, 2'b10, edges[i]);
			op(1'b0, 2'b11, edges[i] | 32'h001E_0000);
		end
		// Random traffic over the buffer, aliased addresses, meeting refresh
		for (int i = 0; i < 30; i++) begin
			a = ((rnd() % 32'h40) << 1) | (rnd() & 32'h001E_0000);
			op(1'(rnd()), 2'((rnd() % 3) + 1), a);
		end
		final_report();
	end
endmodule
